// *** shared/mac_timing_pkg.sv ***
// Constants and types for the modem identifier decode and protocol timers
package mac_timing_pkg;

	localparam int CLK_NS = 40;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES_DEF = MS_NS / CLK_NS;
	localparam int TICK_W = 16;

	localparam int SID_W = 14;
	localparam int PID_W = 13;
	localparam int MAC_W = 48;
	localparam int SLOT_W = 13;
	localparam int PRIO_W = 3;
	localparam int NSLOT_W = 4;

	localparam logic [SID_W-1:0] SID_NONE = 14'h0000;
	localparam logic [SID_W-1:0] SID_ALL = 14'h3FFF;
	localparam logic [SID_W-1:0] SID_MCAST_LO = 14'h3FF1;
	localparam logic [SID_W-1:0] SID_MCAST_HI = 14'h3FFE;
	localparam logic [5:0] SID_PRIO_HI = 6'h3E;
	localparam int SID_HI_LSB = 8;
	localparam logic [PID_W-1:0] PID_DATA = 13'h1FFE;
	localparam logic [MAC_W-1:0] RESERVED_FIRST = 48'h0000_0000_0001;
	localparam logic [MAC_W-1:0] RESERVED_SPAN = 48'h0000_0000_000E;

	// Timer indices
	localparam int NUM_TMR = 7;
	localparam int TMR_SYNC = 0;
	localparam int TMR_DESC = 1;
	localparam int TMR_BCAST = 2;
	localparam int TMR_RSP = 3;
	localparam int TMR_UCAST = 4;
	localparam int TMR_REG = 5;
	localparam int TMR_CFG = 6;
	localparam int TMR_W = 17;

	// Times in milliseconds, one timer tick per millisecond
	localparam int SYNC_LOST_MS = 600;
	localparam int DESC_INTERVAL_MS = 2000;
	localparam int RANGING_INTERVAL_MS = 2000;
	localparam int WAIT_FACTOR = 5;
	localparam int RSP_MIN_MS = 50;
	localparam int RSP_MAX_MS = 200;
	localparam int RSP_DEFAULT_MS = 200;
	localparam int UCAST_MIN_MS = 30000;
	localparam int UCAST_MAX_MS = 35000;
	localparam int REG_REPLY_MS = 3000;
	localparam int CONFIG_TO_REG_MS = 30000;

	// Retry counters
	localparam int NUM_RETRY = 4;
	localparam int RTY_CONT = 0;
	localparam int RTY_REQ = 1;
	localparam int RTY_DATA = 2;
	localparam int RTY_REG = 3;
	localparam int RETRY_W = 5;
	localparam logic [RETRY_W-1:0] RETRY_MIN = 5'h10;
	localparam logic [RETRY_W-1:0] REG_RETRY_MIN = 5'h03;

	// Register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_OWN_SID = 8'h04;
	localparam logic [ADDR_W-1:0] REG_RSP_MS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_PENDING_MS = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_UCAST_MS = 8'h10;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] REG_RETRY_CNT = 8'h18;
	localparam int CTRL_INIT_BIT = 0;
	localparam int CTRL_PRIO_LSB = 1;
	localparam int STAT_EXH_LSB = 8;
	localparam int STAT_LOST_BIT = 16;
	localparam int CNT_FIELD_W = 8;
	localparam int MS_W = 16;

	typedef enum logic [2:0] {
		SIDK_NONE,
		SIDK_ALL,
		SIDK_MCAST,
		SIDK_PRIO,
		SIDK_OWN,
		SIDK_OTHER
	} sid_kind_type;

endpackage

// *** shared/timer_if.sv ***
// Control and status bundle between the timer bank and one wait timer
`timescale 1ns/1ns
interface timer_if;
	logic tick;
	logic start;
	logic halt;
	logic [mac_timing_pkg::TMR_W-1:0] limit;
	logic expired;
	logic running;

	modport ctl(output tick, output start, output halt, output limit, input expired, input running);
	modport tmr(input tick, input start, input halt, input limit, output expired, output running);
endinterface

// *** verilog/wait_timer.sv ***
// Wait timer counting millisecond ticks up to its limit, with restart, halt and expiry pulse
`timescale 1ns/1ns
module wait_timer (
	input wire logic sys_clk,
	input wire logic rst_b,
	timer_if.tmr tif
);
	import mac_timing_pkg::*;

	logic [TMR_W-1:0] count_q, count_d;
	logic run_q, run_d;
	logic exp_q, exp_d;

	// Start beats halt so a restart in the same cycle is never lost
	always_comb begin
		count_d = count_q;
		run_d = run_q;
		exp_d = 1'b0;
		if (tif.start) begin
			count_d = '0;
			run_d = 1'b1;
		end else if (tif.halt) begin
			run_d = 1'b0;
		end else if (run_q && tif.tick) begin
			if (count_q + TMR_W'(1) >= tif.limit) begin
				exp_d = 1'b1;
				run_d = 1'b0;
			end else begin
				count_d = count_q + TMR_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			count_q <= '0;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end else begin
			count_q <= count_d;
			run_q <= run_d;
			exp_q <= exp_d;
		end
	end

	assign tif.expired = exp_q;
	assign tif.running = run_q;
endmodule // wait_timer

// *** verilog/mac_sid_timers.sv ***
// Address, identifier and packet filters with retry counters and wait timers
`timescale 1ns/1ns
module mac_sid_timers #(
	parameter int TICK_CYCLES = mac_timing_pkg::TICK_CYCLES_DEF,
	// Arbitrary neutral all-modem group address
	parameter logic [47:0] ALL_MODEM_ADDR = 48'h0300_0000_1000
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [mac_timing_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [mac_timing_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [mac_timing_pkg::DATA_W-1:0] reg_rdata,
	input wire logic dest_valid,
	input wire logic [mac_timing_pkg::MAC_W-1:0] dest_addr,
	output logic addr_accept,
	output logic addr_local_only,
	input wire logic pid_valid,
	input wire logic [mac_timing_pkg::PID_W-1:0] pid,
	output logic pid_accept,
	input wire logic elem_valid,
	input wire logic [mac_timing_pkg::SID_W-1:0] elem_sid,
	input wire logic elem_reqdata,
	input wire logic elem_request,
	input wire logic [mac_timing_pkg::SLOT_W-1:0] elem_slot,
	output logic tx_allowed,
	output logic [mac_timing_pkg::NSLOT_W-1:0] tx_max_slots,
	output mac_timing_pkg::sid_kind_type sid_kind,
	output logic [mac_timing_pkg::SID_W-1:0] own_sid,
	input wire logic [mac_timing_pkg::NUM_TMR-1:0] timer_start,
	input wire logic [mac_timing_pkg::NUM_TMR-1:0] timer_stop,
	output logic [mac_timing_pkg::NUM_TMR-1:0] timer_expired,
	output logic sync_lost,
	input wire logic [mac_timing_pkg::NUM_RETRY-1:0] retry_fail,
	input wire logic [mac_timing_pkg::NUM_RETRY-1:0] retry_ok,
	output logic [mac_timing_pkg::NUM_RETRY-1:0] retry_exhausted
);
	import mac_timing_pkg::*;

	function automatic logic [MS_W-1:0] clamp_ms(input logic [MS_W-1:0] v,
		input logic [MS_W-1:0] lo, input logic [MS_W-1:0] hi);
		if (v < lo) return lo;
		if (v > hi) return hi;
		return v;
	endfunction

	function automatic logic slot_ok(input logic [SLOT_W-1:0] slot,
		input logic [NSLOT_W-1:0] n);
		return (slot % SLOT_W'(n)) == '0;
	endfunction

	function automatic logic [RETRY_W-1:0] retry_limit(input int idx);
		return (idx == RTY_REG) ? REG_RETRY_MIN : RETRY_MIN;
	endfunction

	// Millisecond tick
	logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic tick_q, tick_d;

	always_comb begin
		tick_cnt_d = tick_cnt_q + TICK_W'(1);
		tick_d = 1'b0;
		if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	// Software registers
	logic init_q, init_d;
	logic [PRIO_W-1:0] prio_q, prio_d;
	logic [SID_W-1:0] own_cfg_q, own_cfg_d;
	logic [MS_W-1:0] rsp_ms_q, rsp_ms_d;
	logic [MS_W-1:0] pend_ms_q, pend_ms_d;
	logic [MS_W-1:0] ucast_ms_q, ucast_ms_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [NUM_TMR-1:0] w1c_exp;
	logic [NUM_RETRY-1:0] w1c_exh;
	logic [NUM_TMR-1:0] exp_q, exp_d;
	logic [NUM_RETRY-1:0] exh_q, exh_d;
	logic lost_q, lost_d;
	logic [RETRY_W-1:0] rcnt_q [NUM_RETRY];
	logic [RETRY_W-1:0] rcnt_d [NUM_RETRY];

	always_comb begin
		init_d = init_q;
		prio_d = prio_q;
		own_cfg_d = own_cfg_q;
		rsp_ms_d = rsp_ms_q;
		pend_ms_d = pend_ms_q;
		ucast_ms_d = ucast_ms_q;
		rdata_d = '0;
		w1c_exp = '0;
		w1c_exh = '0;
		if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL: begin
					init_d = reg_wdata[CTRL_INIT_BIT];
					prio_d = reg_wdata[CTRL_PRIO_LSB +: PRIO_W];
				end
				REG_OWN_SID: own_cfg_d = reg_wdata[SID_W-1:0];
				REG_RSP_MS: rsp_ms_d = clamp_ms(reg_wdata[MS_W-1:0], MS_W'(RSP_MIN_MS),
					MS_W'(RSP_MAX_MS));
				REG_PENDING_MS: pend_ms_d = reg_wdata[MS_W-1:0];
				REG_UCAST_MS: ucast_ms_d = clamp_ms(reg_wdata[MS_W-1:0], MS_W'(UCAST_MIN_MS),
					MS_W'(UCAST_MAX_MS));
				REG_STATUS: begin
					w1c_exp = reg_wdata[NUM_TMR-1:0];
					w1c_exh = reg_wdata[STAT_EXH_LSB +: NUM_RETRY];
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: rdata_d = DATA_W'({prio_q, init_q});
				REG_OWN_SID: rdata_d = DATA_W'(own_cfg_q);
				REG_RSP_MS: rdata_d = DATA_W'(rsp_ms_q);
				REG_PENDING_MS: rdata_d = DATA_W'(pend_ms_q);
				REG_UCAST_MS: rdata_d = DATA_W'(ucast_ms_q);
				REG_STATUS: begin
					rdata_d[NUM_TMR-1:0] = exp_q;
					rdata_d[STAT_EXH_LSB +: NUM_RETRY] = exh_q;
					rdata_d[STAT_LOST_BIT] = lost_q;
				end
				REG_RETRY_CNT: begin
					for (int i = 0; i < NUM_RETRY; i++) begin
						rdata_d[i*CNT_FIELD_W +: CNT_FIELD_W] = CNT_FIELD_W'(rcnt_q[i]);
					end
				end
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			init_q <= 1'b0;
			prio_q <= '0;
			own_cfg_q <= SID_NONE;
			rsp_ms_q <= MS_W'(RSP_DEFAULT_MS);
			pend_ms_q <= '0;
			ucast_ms_q <= MS_W'(UCAST_MIN_MS);
			rdata_q <= '0;
		end else begin
			init_q <= init_d;
			prio_q <= prio_d;
			own_cfg_q <= own_cfg_d;
			rsp_ms_q <= rsp_ms_d;
			pend_ms_q <= pend_ms_d;
			ucast_ms_q <= ucast_ms_d;
			rdata_q <= rdata_d;
		end
	end

	// Filters and allocation decode
	logic accept_q, accept_d, local_q, local_d, pid_q, pid_d;
	logic tx_q, tx_d;
	logic [NSLOT_W-1:0] max_q, max_d;
	sid_kind_type kind_q, kind_d;
	logic [SID_W-1:0] own_q, own_d;
	logic [MAC_W-1:0] addr_diff;
	logic mc_ok_c, prio_ok_c, is_mcast_c;

	always_comb begin
		accept_d = accept_q;
		local_d = local_q;
		pid_d = pid_q;
		tx_d = tx_q;
		max_d = max_q;
		kind_d = kind_q;
		own_d = init_q ? SID_NONE : own_cfg_q;
		addr_diff = dest_addr - ALL_MODEM_ADDR;
		is_mcast_c = elem_sid >= SID_MCAST_LO && elem_sid <= SID_MCAST_HI;
		mc_ok_c = slot_ok(elem_slot, elem_sid[NSLOT_W-1:0]);
		prio_ok_c = elem_sid[prio_q];
		if (dest_valid) begin
			accept_d = dest_addr == ALL_MODEM_ADDR;
			local_d = addr_diff >= RESERVED_FIRST && addr_diff <= RESERVED_SPAN;
		end
		if (pid_valid) begin
			pid_d = pid == PID_DATA;
		end
		if (elem_valid) begin
			max_d = '0;
			if (elem_sid == SID_NONE) begin
				kind_d = SIDK_NONE;
				tx_d = 1'b0;
			end else if (elem_sid == SID_ALL) begin
				kind_d = SIDK_ALL;
				tx_d = 1'b1;
			end else if (is_mcast_c) begin
				kind_d = SIDK_MCAST;
				tx_d = elem_reqdata && mc_ok_c;
				max_d = elem_sid[NSLOT_W-1:0];
			end else if (elem_sid[SID_W-1:SID_HI_LSB] == SID_PRIO_HI) begin
				kind_d = SIDK_PRIO;
				tx_d = elem_request && prio_ok_c;
			end else if (elem_sid == own_d) begin
				kind_d = SIDK_OWN;
				tx_d = 1'b1;
			end else begin
				kind_d = SIDK_OTHER;
				tx_d = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			accept_q <= 1'b0;
			local_q <= 1'b0;
			pid_q <= 1'b0;
			tx_q <= 1'b0;
			max_q <= '0;
			kind_q <= SIDK_NONE;
			own_q <= SID_NONE;
		end else begin
			accept_q <= accept_d;
			local_q <= local_d;
			pid_q <= pid_d;
			tx_q <= tx_d;
			max_q <= max_d;
			kind_q <= kind_d;
			own_q <= own_d;
		end
	end

	// Timer bank
	timer_if tif [NUM_TMR] ();
	logic [TMR_W-1:0] tmr_limit [NUM_TMR];
	logic [NUM_TMR-1:0] tmr_exp;

	always_comb begin
		tmr_limit[TMR_SYNC] = TMR_W'(SYNC_LOST_MS);
		tmr_limit[TMR_DESC] = TMR_W'(WAIT_FACTOR * DESC_INTERVAL_MS);
		tmr_limit[TMR_BCAST] = TMR_W'(WAIT_FACTOR * RANGING_INTERVAL_MS);
		tmr_limit[TMR_RSP] = TMR_W'(rsp_ms_q);
		tmr_limit[TMR_UCAST] = TMR_W'(ucast_ms_q) + TMR_W'(pend_ms_q);
		tmr_limit[TMR_REG] = TMR_W'(REG_REPLY_MS);
		tmr_limit[TMR_CFG] = TMR_W'(CONFIG_TO_REG_MS);
	end

	for (genvar gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
		assign tif[gi].tick = tick_q;
		assign tif[gi].start = timer_start[gi];
		assign tif[gi].halt = timer_stop[gi];
		assign tif[gi].limit = tmr_limit[gi];
		assign tmr_exp[gi] = tif[gi].expired;
		wait_timer u_tmr (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.tif(tif[gi])
		);
	end

	// Sticky flags: a new event wins over a clear in the same cycle
	always_comb begin
		exp_d = (exp_q & ~(timer_start | w1c_exp)) | tmr_exp;
		lost_d = lost_q;
		if (tmr_exp[TMR_SYNC]) begin
			lost_d = 1'b1;
		end else if (timer_start[TMR_SYNC]) begin
			lost_d = 1'b0;
		end
		exh_d = exh_q & ~w1c_exh;
		for (int i = 0; i < NUM_RETRY; i++) begin
			rcnt_d[i] = rcnt_q[i];
			if (retry_fail[i]) begin
				if (rcnt_q[i] < retry_limit(i)) begin
					rcnt_d[i] = rcnt_q[i] + RETRY_W'(1);
				end else begin
					exh_d[i] = 1'b1;
				end
			end else if (retry_ok[i]) begin
				rcnt_d[i] = '0;
				exh_d[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			exp_q <= '0;
			lost_q <= 1'b0;
			exh_q <= '0;
			for (int i = 0; i < NUM_RETRY; i++) begin
				rcnt_q[i] <= '0;
			end
		end else begin
			exp_q <= exp_d;
			lost_q <= lost_d;
			exh_q <= exh_d;
			rcnt_q <= rcnt_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign addr_accept = accept_q;
	assign addr_local_only = local_q;
	assign pid_accept = pid_q;
	assign tx_allowed = tx_q;
	assign tx_max_slots = max_q;
	assign sid_kind = kind_q;
	assign own_sid = own_q;
	assign timer_expired = exp_q;
	assign sync_lost = lost_q;
	assign retry_exhausted = exh_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_all_addr_accept: assert property (
		dest_valid && dest_addr == ALL_MODEM_ADDR |=> addr_accept && !addr_local_only)
		else $error("all-modem address not accepted");
	a_reserved_local: assert property (
		dest_valid && addr_diff >= RESERVED_FIRST && addr_diff <= RESERVED_SPAN
		|=> addr_local_only && !addr_accept)
		else $error("reserved address not kept local");
	a_zero_sid_silent: assert property (
		elem_valid && elem_sid == SID_NONE |=> !tx_allowed && sid_kind == SIDK_NONE)
		else $error("transmit allowed on identifier zero");
	a_all_sid_open: assert property (
		elem_valid && elem_sid == SID_ALL |=> tx_allowed && sid_kind == SIDK_ALL)
		else $error("all-modem identifier not open");
	a_mcast_reqdata_only: assert property (
		elem_valid && is_mcast_c && !elem_reqdata |=> !tx_allowed && sid_kind == SIDK_MCAST)
		else $error("multicast used outside request/data element");
	a_mcast_stride: assert property (
		elem_valid && is_mcast_c && elem_reqdata
		|=> tx_allowed == $past(mc_ok_c) && tx_max_slots == $past(elem_sid[NSLOT_W-1:0]))
		else $error("multicast stride or length wrong");
	a_prio_mask: assert property (
		elem_valid && elem_sid[SID_W-1:SID_HI_LSB] == SID_PRIO_HI
		|=> tx_allowed == ($past(elem_request) && $past(prio_ok_c)))
		else $error("priority request mask misapplied");
	a_pid_select: assert property (
		pid_valid |=> pid_accept == ($past(pid) == PID_DATA))
		else $error("packet identifier filter wrong");
	a_sync_lost_flag: assert property (
		tmr_exp[TMR_SYNC] |=> sync_lost && timer_expired[TMR_SYNC])
		else $error("sync loss not declared");
	a_cont_retry_floor: assert property (
		$rose(retry_exhausted[RTY_CONT]) |-> $past(rcnt_q[RTY_CONT]) == RETRY_MIN)
		else $error("ranging retries abandoned early");
	a_reg_retry_floor: assert property (
		retry_fail[RTY_REG] && rcnt_q[RTY_REG] == REG_RETRY_MIN && !retry_exhausted[RTY_REG]
		|=> retry_exhausted[RTY_REG] && rcnt_q[RTY_REG] == REG_RETRY_MIN)
		else $error("registration retries not honoured");
	a_rsp_range: assert property (
		reg_wr && reg_addr == REG_RSP_MS
		|=> rsp_ms_q >= MS_W'(RSP_MIN_MS) && rsp_ms_q <= MS_W'(RSP_MAX_MS))
		else $error("response timeout out of range");
	a_init_sid_zero: assert property (
		init_q |=> own_sid == SID_NONE)
		else $error("ranging identifier not zero");
endmodule // mac_sid_timers

// *** dv/headend_model.sv ***
// Behavioural head-end that sends timing messages to the modem
`timescale 1ns/1ns
module headend_model (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic sync_on,
	input wire logic [15:0] sync_gap,
	output logic sync_pulse
);
	logic [15:0] cnt_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b || !sync_on) begin
			cnt_q <= 16'h0000;
			sync_pulse <= 1'b0;
		end else if (cnt_q == sync_gap - 16'h0001) begin
			cnt_q <= 16'h0000;
			sync_pulse <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			sync_pulse <= 1'b0;
		end
	end
endmodule // headend_model

// *** dv/testbench.sv ***
// Self-checking bench for the identifier decode and protocol timers
`timescale 1ns/1ns
module testbench;
	import mac_timing_pkg::*;
	localparam int TCK = 4;
	// Arbitrary group address
	localparam logic [47:0] GROUP = 48'h0300_0000_1000;
	logic sys_clk, rst_b, reg_wr, reg_rd, dest_valid, pid_valid, elem_valid;
	logic elem_reqdata, elem_request, addr_accept, addr_local_only, pid_accept;
	logic tx_allowed, sync_lost, sync_on, sync_pulse;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [47:0] dest_addr;
	logic [12:0] pid, elem_slot;
	logic [13:0] elem_sid, own_sid;
	logic [3:0] tx_max_slots, retry_fail, retry_ok, retry_exhausted;
	logic [6:0] tb_start, timer_stop, timer_expired;
	wire logic [6:0] timer_start;
	logic [15:0] sync_gap;
	sid_kind_type sid_kind;
	int fail_count = 0;
	int tests_run = 0;

	assign timer_start = tb_start | {6'h00, sync_pulse};

	mac_sid_timers #(.TICK_CYCLES(TCK), .ALL_MODEM_ADDR(GROUP)) i_dut (.sys_clk(sys_clk),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .dest_valid(dest_valid),
		.dest_addr(dest_addr), .addr_accept(addr_accept), .addr_local_only(addr_local_only),
		.pid_valid(pid_valid), .pid(pid), .pid_accept(pid_accept), .elem_valid(elem_valid),
		.elem_sid(elem_sid), .elem_reqdata(elem_reqdata), .elem_request(elem_request),
		.elem_slot(elem_slot), .tx_allowed(tx_allowed), .tx_max_slots(tx_max_slots),
		.sid_kind(sid_kind), .own_sid(own_sid), .timer_start(timer_start),
		.timer_stop(timer_stop), .timer_expired(timer_expired), .sync_lost(sync_lost),
		.retry_fail(retry_fail), .retry_ok(retry_ok), .retry_exhausted(retry_exhausted));

	headend_model i_headend (.sys_clk(sys_clk), .rst_b(rst_b), .sync_on(sync_on),
		.sync_gap(sync_gap), .sync_pulse(sync_pulse));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic complete_run();
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic send_elem(input logic [13:0] s, input logic q, input logic r, input int sl);
		@(posedge sys_clk);
		elem_sid <= s;
		elem_reqdata <= q;
		elem_request <= r;
		elem_slot <= 13'(sl);
		elem_valid <= 1'b1;
		@(posedge sys_clk);
		elem_valid <= 1'b0;
		#1;
	endtask

	task automatic t_reset();
		reg_read(REG_RSP_MS, rd);
		check(rd, 32'(RSP_DEFAULT_MS), "rsp default");
		reg_read(REG_UCAST_MS, rd);
		check(rd, 32'(UCAST_MIN_MS), "ucast default");
		reg_read(8'h1C, rd);
		check(rd, 32'h0000_0000, "unmapped read");
	endtask

	task automatic t_filters();
		for (int k = 0; k < 16; k++) begin
			@(posedge sys_clk);
			dest_addr <= GROUP + 48'(k);
			dest_valid <= 1'b1;
			pid <= (k == 0) ? PID_DATA : PID_DATA ^ 13'(k);
			pid_valid <= 1'b1;
			@(posedge sys_clk);
			dest_valid <= 1'b0;
			pid_valid <= 1'b0;
			#1;
			check(32'(addr_accept), 32'(k == 0), "group accept");
			check(32'(addr_local_only), 32'(k >= 1 && k <= 14), "reserved local");
			check(32'(pid_accept), 32'(k == 0), "pid select");
		end
	endtask

	task automatic t_sid();
		send_elem(SID_NONE, 1'b1, 1'b0, 0);
		check(32'(tx_allowed), 32'h0000_0000, "none tx");
		check(32'(sid_kind), 32'(SIDK_NONE), "none kind");
		send_elem(SID_ALL, 1'b0, 1'b1, 5);
		check(32'(tx_allowed), 32'h0000_0001, "all tx");
		check(32'(sid_kind), 32'(SIDK_ALL), "all kind");
		check(32'(tx_max_slots), 32'h0000_0000, "all no limit");
		for (int n = 1; n <= 14; n++) begin
			for (int s = 0; s <= 2 * n; s++) begin
				send_elem(SID_MCAST_LO + 14'(n - 1), 1'b1, 1'b0, s);
				check(32'(tx_allowed), 32'(s % n == 0), "mcast start");
				check(32'(tx_max_slots), 32'(n), "mcast size");
				check(32'(sid_kind), 32'(SIDK_MCAST), "mcast kind");
			end
		end
		send_elem(SID_MCAST_LO + 14'h0001, 1'b0, 1'b1, 0);
		check(32'(tx_allowed), 32'h0000_0000, "mcast not reqdata");
	endtask

	task automatic t_prio();
		logic [7:0] mask;
		mask = 8'hA5;
		for (int p = 0; p < 8; p++) begin
			reg_write(REG_CTRL, 32'(p) << CTRL_PRIO_LSB);
			send_elem({SID_PRIO_HI, mask}, 1'b0, 1'b1, 0);
			check(32'(tx_allowed), 32'(mask[p]), "prio mask");
			check(32'(sid_kind), 32'(SIDK_PRIO), "prio kind");
		end
		reg_write(REG_OWN_SID, 32'h0000_0123);
		reg_write(REG_CTRL, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		check(32'(own_sid), 32'h0000_0000, "init sid");
		reg_write(REG_CTRL, 32'h0000_0000);
		repeat (2) @(posedge sys_clk);
		check(32'(own_sid), 32'h0000_0123, "own sid");
		send_elem(14'h0123, 1'b0, 1'b0, 0);
		check(32'(tx_allowed), 32'h0000_0001, "own tx");
		check(32'(sid_kind), 32'(SIDK_OWN), "own kind");
		send_elem(14'h0124, 1'b1, 1'b1, 0);
		check(32'(tx_allowed), 32'h0000_0000, "other tx");
		check(32'(sid_kind), 32'(SIDK_OTHER), "other kind");
	endtask

	task automatic t_halt();
		@(posedge sys_clk);
		tb_start[TMR_RSP] <= 1'b1;
		@(posedge sys_clk);
		tb_start[TMR_RSP] <= 1'b0;
		timer_stop[TMR_RSP] <= 1'b1;
		@(posedge sys_clk);
		timer_stop[TMR_RSP] <= 1'b0;
		repeat (RSP_MIN_MS * TCK + 8) @(posedge sys_clk);
		#1 check(32'(timer_expired[TMR_RSP]), 32'h0000_0000, "halted expired");
	endtask

	// Expiry must land inside one tick of the nominal time
	task automatic t_timer(input int idx, input int lim);
		int n;
		@(posedge sys_clk);
		tb_start[idx] <= 1'b1;
		@(posedge sys_clk);
		tb_start[idx] <= 1'b0;
		#1 n = 1;
		while (timer_expired[idx] !== 1'b1 && n < lim * TCK + 4) begin
			@(posedge sys_clk);
			#1 n++;
		end
		check(32'(n >= (lim - 1) * TCK + 1 && n <= lim * TCK + 2), 32'h0000_0001, "expiry time");
		reg_read(REG_STATUS, rd);
		check(32'(rd[idx]), 32'h0000_0001, "status expired");
	endtask

	task automatic t_timers();
		reg_write(REG_RSP_MS, 32'h0000_012C);
		reg_read(REG_RSP_MS, rd);
		check(rd, 32'(RSP_MAX_MS), "rsp clamp high");
		reg_write(REG_RSP_MS, 32'h0000_000A);
		reg_read(REG_RSP_MS, rd);
		check(rd, 32'(RSP_MIN_MS), "rsp clamp low");
		t_timer(TMR_RSP, RSP_MIN_MS);
		t_timer(TMR_REG, REG_REPLY_MS);
	endtask

	task automatic t_sync();
		int n;
		@(posedge sys_clk);
		sync_gap <= 16'(200 * TCK);
		sync_on <= 1'b1;
		repeat (3000) @(posedge sys_clk);
		#1 check(32'(sync_lost), 32'h0000_0000, "sync fed");
		@(posedge sys_clk);
		sync_on <= 1'b0;
		n = 0;
		while (sync_lost !== 1'b1 && n < 800 * TCK + 4) begin
			@(posedge sys_clk);
			#1 n++;
		end
		check(32'(n <= 800 * TCK + 2), 32'h0000_0001, "sync lost late");
		check(32'(n >= (SYNC_LOST_MS - 201) * TCK), 32'h0000_0001, "sync lost early");
	endtask

	task automatic t_retry();
		int lim;
		for (int i = 0; i < 4; i++) begin
			lim = (i == RTY_REG) ? 3 : 16;
			for (int k = 0; k <= lim + 1; k++) begin
				@(posedge sys_clk);
				retry_fail[i] <= (k <= lim);
				retry_ok[i] <= (k > lim);
				@(posedge sys_clk);
				retry_fail <= 4'h0;
				retry_ok <= 4'h0;
				#1;
				if (k == lim - 1) begin
					check(32'(retry_exhausted[i]), 32'h0000_0000, "early exhaust");
					reg_read(REG_RETRY_CNT, rd);
					check((rd >> (8 * i)) & 32'h0000_00FF, 32'(lim), "retry count");
				end
				if (k == lim) begin
					check(32'(retry_exhausted[i]), 32'h0000_0001, "exhaust");
				end
			end
			check(32'(retry_exhausted[i]), 32'h0000_0000, "ok clears");
		end
	endtask

	initial begin
		#(40 * 80000);
		fail_count++;
		complete_run();
	end

	initial begin
		rst_b <= 1'b0;
		{reg_wr, reg_rd, dest_valid, pid_valid, elem_valid, sync_on} <= 6'h00;
		{elem_reqdata, elem_request} <= 2'h0;
		reg_addr <= 8'h00;
		reg_wdata <= 32'h0000_0000;
		dest_addr <= 48'h0000_0000_0000;
		pid <= 13'h0000;
		elem_sid <= 14'h0000;
		elem_slot <= 13'h0000;
		tb_start <= 7'h00;
		timer_stop <= 7'h00;
		retry_fail <= 4'h0;
		retry_ok <= 4'h0;
		sync_gap <= 16'h0001;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset();
		t_filters();
		t_sid();
		t_prio();
		t_timers();
		t_halt();
		t_sync();
		t_retry();
		complete_run();
	end
endmodule // testbench
